// >>> hw/ipc_codec.sv
`timescale 1ns/1ps
// Behaviour
// - Each serial bit period holds exactly 16 bit ticks.
// - Ticks time start and eight data bits; stop bit timed on transmit and host receive, not on infrared receive.
// - Host serial side is half duplex: one direction at a time.
// - Rate pins set host rate only; infrared rate chosen separately.
// - Codes 00..11 give osc/1152, /576, /192, /96 host bit rates.
// - Zero bit: infrared output low 7 ticks, high 3, low 6.
// - One bit: infrared output low for all 16 ticks.
// - Infrared output may lag host bits; pattern depends on value only.
// - Received zero: input low first 3 ticks, then high 13.
// - Received one: input high for all 16 ticks.
// - Host serial output holds each bit level for a full 16 ticks.
// - Fully demodulated bytes go to the host as async serial data.
// - Enable low is watched always; it stops operation into low power.
// - After enable returns high, no traffic for 1024 oscillator periods.
// - Reset holds the block; after release a reset sequence runs first.
module ipc_codec import ipc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Power control and rate straps
   input wire logic enable,
   input wire logic rateSelHi,
   input wire logic rateSelLo,
   input wire logic [2:0] irRateSel,
   // Host serial lines
   input wire logic hostTxd,
   output logic hostRxd,
   // Infrared transceiver lines
   input wire logic irPulseIn,
   output logic irPulseOut,
   // Status
   output logic lowPower,
   output logic linkReady
);
   logic [SYNC_W-1:0] syncA_reg, syncB_reg;
   logic enS, hostTxdS, irInS, halt;
   logic [1:0] tick, restart, txIdle, load, txLine;
   logic [TICK_W-1:0] tickDiv [2];
   logic active_reg, active_next, lowPower_reg, lowPower_next;
   logic linkReady_reg, linkReady_next;
   logic [WAKE_W-1:0] wakeCnt_reg, wakeCnt_next;
   ipc_dir_type dir_reg, dir_next;
   ipc_ser_type hrState_reg, hrState_next, irState_reg, irState_next;
   logic [PHASE_W-1:0] hrPhase_reg, hrPhase_next, irPhase_reg, irPhase_next;
   logic [2:0] hrBit_reg, hrBit_next, irBit_reg, irBit_next;
   logic [DATA_BITS-1:0] hrShift_reg, hrShift_next, irShift_reg, irShift_next;
   logic irSeen_reg, irSeen_next;
   logic hostStart, irStart, allowHost, allowIr;
   logic bufInValid, bufInReady, bufOutValid, bufOutReady;
   logic [DATA_BITS-1:0] bufInData, bufOutData;

   // Pins are asynchronous to clk; nothing reads syncA_reg but syncB_reg
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         syncA_reg <= SYNC_RESET;
         syncB_reg <= SYNC_RESET;
      end
      else
      begin
         syncA_reg <= {enable, rateSelHi, rateSelLo, irRateSel, hostTxd,
                       irPulseIn};
         syncB_reg <= syncA_reg;
      end
   end

   assign enS = syncB_reg[SY_EN];
   assign hostTxdS = syncB_reg[SY_HTXD];
   assign irInS = syncB_reg[SY_IRIN];
   assign halt = !active_reg;
   // Host rate from straps only; infrared rate from its own select
   assign tickDiv[CH_HOST] = HOST_TICK_CYC[{syncB_reg[SY_RHI],
                                            syncB_reg[SY_RLO]}];
   assign tickDiv[CH_IR] =
      (syncB_reg[SY_IRRATE +: 3] > IR_RATE_LAST) ? IR_TICK_CYC[0] :
      IR_TICK_CYC[syncB_reg[SY_IRRATE +: 3]];
   assign restart[CH_HOST] = hostStart;
   assign restart[CH_IR] = irStart;

   // Power, wake-up delay and direction
   always_comb
   begin
      lowPower_next = 1'b0;
      active_next = active_reg;
      wakeCnt_next = wakeCnt_reg;
      dir_next = dir_reg;
      if (!enS)
      begin
         lowPower_next = 1'b1;
         active_next = 1'b0;
         wakeCnt_next = '0;
      end
      else if (!active_reg)
      begin
         // Reset release and enable rising both pass through this delay
         if (wakeCnt_reg == WAKE_CYC - 1'b1)
            active_next = 1'b1;
         else
            wakeCnt_next = wakeCnt_reg + 1'b1;
      end
      if (halt)
         dir_next = DIR_IDLE;
      else
         unique case (dir_reg)
            DIR_IDLE:
               if (hostStart)
                  dir_next = DIR_TOIR;
               else if (irStart)
                  dir_next = DIR_TOHOST;
            DIR_TOIR:
               if (hrState_reg == SER_IDLE && txIdle[CH_IR] && !bufOutValid)
                  dir_next = DIR_IDLE;
            DIR_TOHOST:
               if (irState_reg == SER_IDLE && txIdle[CH_HOST] &&
                   !bufOutValid)
                  dir_next = DIR_IDLE;
            default:
               dir_next = DIR_IDLE;
         endcase
      linkReady_next = active_next && dir_next != DIR_TOHOST && bufInReady;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         lowPower_reg <= 1'b1;
         active_reg <= 1'b0;
         wakeCnt_reg <= '0;
         dir_reg <= DIR_IDLE;
         linkReady_reg <= 1'b0;
      end
      else
      begin
         lowPower_reg <= lowPower_next;
         active_reg <= active_next;
         wakeCnt_reg <= wakeCnt_next;
         dir_reg <= dir_next;
         linkReady_reg <= linkReady_next;
      end
   end

   // Host line wins a tie so a start bit is never cut
   assign allowHost = active_reg && dir_reg != DIR_TOHOST;
   assign allowIr = active_reg && (dir_reg == DIR_TOHOST ||
                    (dir_reg == DIR_IDLE && hostTxdS));

   // Tick dividers, restarted on a start edge to centre sampling
   for (genvar ch = 0; ch < 2; ch++)
   begin : gTick
      logic [TICK_W-1:0] cnt_reg, cnt_next;
      logic tick_reg, tick_next;
      always_comb
      begin
         cnt_next = cnt_reg + 1'b1;
         tick_next = 1'b0;
         if (halt || restart[ch])
            cnt_next = '0;
         else if (cnt_reg >= tickDiv[ch] - 1'b1)
         begin
            cnt_next = '0;
            tick_next = 1'b1;
         end
      end
      always_ff @(posedge clk)
      begin
         if (reset)
         begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
         end
         else
         begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
         end
      end
      assign tick[ch] = tick_reg;
   end

   // Host serial receiver, 16 ticks per bit, sampled mid-bit
   always_comb
   begin
      hrState_next = hrState_reg;
      hrPhase_next = hrPhase_reg;
      hrBit_next = hrBit_reg;
      hrShift_next = hrShift_reg;
      hostStart = 1'b0;
      if (halt)
         hrState_next = SER_IDLE;
      else
         unique case (hrState_reg)
            SER_IDLE:
               if (allowHost && !hostTxdS)
               begin
                  hostStart = 1'b1;
                  hrState_next = SER_START;
                  hrPhase_next = '0;
                  hrBit_next = '0;
               end
            SER_START, SER_DATA, SER_STOP:
               if (tick[CH_HOST])
               begin
                  hrPhase_next = hrPhase_reg + 1'b1;
                  if (hrPhase_reg == HOST_SAMPLE_PHASE)
                  begin
                     if (hrState_reg == SER_START && hostTxdS)
                        hrState_next = SER_IDLE;
                     else if (hrState_reg == SER_DATA)
                        hrShift_next = {hostTxdS, hrShift_reg[7:1]};
                     else if (hrState_reg == SER_STOP)
                        hrState_next = hostTxdS ? SER_HOLD : SER_IDLE;
                  end
                  if (hrPhase_reg == PHASE_LAST)
                  begin
                     if (hrState_reg == SER_START)
                        hrState_next = SER_DATA;
                     else if (hrState_reg == SER_DATA)
                     begin
                        if (hrBit_reg == LAST_DATA_BIT)
                           hrState_next = SER_STOP;
                        else
                           hrBit_next = hrBit_reg + 1'b1;
                     end
                  end
               end
            SER_HOLD:
               if (bufInReady)
                  hrState_next = SER_IDLE;
            default:
               hrState_next = SER_IDLE;
         endcase
   end

   // Infrared demodulator; stop bit is not timed, frame ends after bit 8
   always_comb
   begin
      irState_next = irState_reg;
      irPhase_next = irPhase_reg;
      irBit_next = irBit_reg;
      irShift_next = irShift_reg;
      irSeen_next = irSeen_reg;
      irStart = 1'b0;
      if (halt)
         irState_next = SER_IDLE;
      else
         unique case (irState_reg)
            SER_IDLE:
               if (allowIr && !irInS)
               begin
                  irStart = 1'b1;
                  irState_next = SER_START;
                  irPhase_next = '0;
                  irBit_next = '0;
                  irSeen_next = 1'b1;
               end
            SER_START, SER_DATA:
               if (tick[CH_IR])
               begin
                  irPhase_next = irPhase_reg + 1'b1;
                  if (irPhase_reg < RX_ZERO_WINDOW && !irInS)
                     irSeen_next = 1'b1;
                  if (irPhase_reg == PHASE_LAST)
                  begin
                     irSeen_next = 1'b0;
                     if (irState_reg == SER_START)
                        irState_next = SER_DATA;
                     else
                     begin
                        // No low seen in the first 8 ticks of the bit decodes as one
                        irShift_next = {!irSeen_reg, irShift_reg[7:1]};
                        if (irBit_reg == LAST_DATA_BIT)
                           irState_next = SER_HOLD;
                        else
                           irBit_next = irBit_reg + 1'b1;
                     end
                  end
               end
            SER_HOLD:
               if (bufInReady)
                  irState_next = SER_IDLE;
            default:
               irState_next = SER_IDLE;
         endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         hrState_reg <= SER_IDLE;
         hrPhase_reg <= '0;
         hrBit_reg <= '0;
         hrShift_reg <= '0;
         irState_reg <= SER_IDLE;
         irPhase_reg <= '0;
         irBit_reg <= '0;
         irShift_reg <= '0;
         irSeen_reg <= 1'b0;
      end
      else
      begin
         hrState_reg <= hrState_next;
         hrPhase_reg <= hrPhase_next;
         hrBit_reg <= hrBit_next;
         hrShift_reg <= hrShift_next;
         irState_reg <= irState_next;
         irPhase_reg <= irPhase_next;
         irBit_reg <= irBit_next;
         irShift_reg <= irShift_next;
         irSeen_reg <= irSeen_next;
      end
   end

   // One buffer serves both directions since only one is ever live
   assign bufInValid = (hrState_reg == SER_HOLD) || (irState_reg == SER_HOLD);
   assign bufInData = (hrState_reg == SER_HOLD) ? hrShift_reg : irShift_reg;
   assign bufOutReady = (dir_reg == DIR_TOHOST && txIdle[CH_HOST]) ||
                        (dir_reg == DIR_TOIR && txIdle[CH_IR]);
   assign load[CH_HOST] = bufOutValid && bufOutReady &&
                          dir_reg == DIR_TOHOST;
   assign load[CH_IR] = bufOutValid && bufOutReady && dir_reg == DIR_TOIR;

   ipc_buffer #(
      .WIDTH(BUF_WIDTH),
      .DEPTH(BUF_DEPTH)
   ) uBuffer (
      .clk(clk),
      .reset(reset),
      .flush(halt),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(bufInData),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOutData)
   );

   // Transmitters: channel 0 drives the host line, channel 1 the emitter
   for (genvar ch = 0; ch < 2; ch++)
   begin : gTx
      ipc_ser_type state_reg, state_next;
      logic [PHASE_W-1:0] phase_reg, phase_next;
      logic [3:0] count_reg, count_next;
      logic [FRAME_BITS-1:0] frame_reg, frame_next;
      logic line_reg, line_next;
      always_comb
      begin
         state_next = state_reg;
         phase_next = phase_reg;
         count_next = count_reg;
         frame_next = frame_reg;
         if (halt)
            state_next = SER_IDLE;
         else
            unique case (state_reg)
               SER_IDLE:
                  if (load[ch])
                  begin
                     state_next = SER_START;
                     frame_next = {1'b1, bufOutData, 1'b0};
                  end
               SER_START:
                  // Wait for a tick so the first bit is a full period
                  if (tick[ch])
                  begin
                     state_next = SER_DATA;
                     phase_next = '0;
                     count_next = '0;
                  end
               SER_DATA:
                  if (tick[ch])
                  begin
                     phase_next = phase_reg + 1'b1;
                     if (phase_reg == PHASE_LAST)
                     begin
                        frame_next = {1'b1, frame_reg[FRAME_BITS-1:1]};
                        if (count_reg == LAST_FRAME_BIT)
                           state_next = SER_IDLE;
                        else
                           count_next = count_reg + 1'b1;
                     end
                  end
               default:
                  state_next = SER_IDLE;
            endcase
         if (ch == CH_HOST)
            line_next = (state_next == SER_DATA) ? frame_next[0] :
                        HOST_IDLE_LEVEL;
         else
            line_next = (state_next == SER_DATA) && !frame_next[0] &&
                        phase_next >= ZERO_PULSE_START &&
                        phase_next < ZERO_PULSE_END;
      end
      always_ff @(posedge clk)
      begin
         if (reset)
         begin
            state_reg <= SER_IDLE;
            phase_reg <= '0;
            count_reg <= '0;
            frame_reg <= '0;
            line_reg <= (ch == CH_HOST) ? HOST_IDLE_LEVEL : IR_IDLE_LEVEL;
         end
         else
         begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            count_reg <= count_next;
            frame_reg <= frame_next;
            line_reg <= line_next;
         end
      end
      assign txIdle[ch] = (state_reg == SER_IDLE);
      assign txLine[ch] = line_reg;
   end

   assign hostRxd = txLine[CH_HOST];
   assign irPulseOut = txLine[CH_IR];
   assign lowPower = lowPower_reg;
   assign linkReady = linkReady_reg;

endmodule : ipc_codec

// >>> inc/ipc_pkg.sv
package ipc_pkg;

   // Oscillator the rates are defined against, and the real fabric clock
   localparam longint OSC_HZ = 11059200;
   localparam longint CLK_HZ = 25000000;

   localparam int TICKS_PER_BIT = 16;
   localparam int TICK_W = 8;
   localparam int PHASE_W = 4;
   localparam logic [PHASE_W-1:0] PHASE_LAST = 4'hf;
   localparam logic [PHASE_W-1:0] HOST_SAMPLE_PHASE = 4'h7;
   localparam logic [PHASE_W-1:0] ZERO_PULSE_START = 4'h7;
   localparam logic [PHASE_W-1:0] ZERO_PULSE_END = 4'ha;
   localparam logic [PHASE_W-1:0] RX_ZERO_WINDOW = 4'h8;

   localparam int DATA_BITS = 8;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;
   localparam int FRAME_BITS = 10;
   localparam logic [3:0] LAST_FRAME_BIT = 4'h9;

   // Bit dividers in oscillator periods; index is the rate code
   localparam longint HOST_OSC_DIV [4] = '{1152, 576, 192, 96};
   localparam longint IR_OSC_DIV [5] = '{1152, 576, 288, 192, 96};
   localparam logic [2:0] IR_RATE_LAST = 3'h4;

   // Fabric cycles per tick, rounded to nearest: 25 MHz is no exact multiple
   function automatic logic [TICK_W-1:0] tickCycles(input longint oscDiv);
      longint den;
      den = OSC_HZ * TICKS_PER_BIT;
      return TICK_W'((CLK_HZ * oscDiv + den / 2) / den);
   endfunction : tickCycles

   localparam logic [TICK_W-1:0] HOST_TICK_CYC [4] = '{
      tickCycles(HOST_OSC_DIV[0]), tickCycles(HOST_OSC_DIV[1]),
      tickCycles(HOST_OSC_DIV[2]), tickCycles(HOST_OSC_DIV[3])};
   localparam logic [TICK_W-1:0] IR_TICK_CYC [5] = '{
      tickCycles(IR_OSC_DIV[0]), tickCycles(IR_OSC_DIV[1]),
      tickCycles(IR_OSC_DIV[2]), tickCycles(IR_OSC_DIV[3]),
      tickCycles(IR_OSC_DIV[4])};

   // Wake-up delay after enable or reset, rounded up to whole cycles
   localparam longint WAKE_OSC_PERIODS = 1024;
   localparam int WAKE_W = 12;
   localparam logic [WAKE_W-1:0] WAKE_CYC =
      WAKE_W'((WAKE_OSC_PERIODS * CLK_HZ + OSC_HZ - 1) / OSC_HZ);

   // Synchroniser bit positions
   localparam int SYNC_W = 8;
   localparam int SY_IRIN = 0;
   localparam int SY_HTXD = 1;
   localparam int SY_IRRATE = 2;
   localparam int SY_RLO = 5;
   localparam int SY_RHI = 6;
   localparam int SY_EN = 7;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h03;

   localparam int CH_HOST = 0;
   localparam int CH_IR = 1;
   localparam logic HOST_IDLE_LEVEL = 1'b1;
   localparam logic IR_IDLE_LEVEL = 1'b0;

   localparam int BUF_WIDTH = 8;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_START = 3'b001,
      SER_DATA = 3'b010,
      SER_STOP = 3'b011,
      SER_HOLD = 3'b100
   } ipc_ser_type;

   typedef enum logic [1:0] {
      DIR_IDLE = 2'b00,
      DIR_TOIR = 2'b01,
      DIR_TOHOST = 2'b10
   } ipc_dir_type;

endpackage : ipc_pkg

// >>> hw/ipc_buffer.sv
`timescale 1ns/1ps
module ipc_buffer import ipc_pkg::*; #(
   parameter int WIDTH = BUF_WIDTH,
   parameter int DEPTH = BUF_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic flush,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [PTR_W-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [CNT_W-1:0] count_reg, count_next;
   logic push, pop;

   assign inReady = (count_reg != CNT_FULL);
   assign outValid = (count_reg != '0);
   assign outData = mem_reg[rdPtr_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb
   begin
      mem_next = mem_reg;
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      count_next = count_reg;
      if (flush)
      begin
         wrPtr_next = '0;
         rdPtr_next = '0;
         count_next = '0;
      end
      else
      begin
         if (push)
         begin
            mem_next[wrPtr_reg] = inData;
            wrPtr_next = (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
         end
         if (pop)
            rdPtr_next = (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
         if (push && !pop)
            count_next = count_reg + 1'b1;
         else if (pop && !push)
            count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
      mem_reg <= mem_next;
   end

endmodule : ipc_buffer

// >>> verif/ipc_codec_checker.sv
`timescale 1ns/1ps
module ipc_codec_checker import ipc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Straps and inputs
   input wire logic enable,
   input wire logic rateSelHi,
   input wire logic rateSelLo,
   input wire logic [2:0] irRateSel,
   input wire logic hostTxd,
   input wire logic irPulseIn,
   // Outputs
   input wire logic hostRxd,
   input wire logic irPulseOut,
   input wire logic lowPower,
   input wire logic linkReady
);
   logic [15:0] hiCnt, runCnt, sinceWake;
   logic lastRxd;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Run lengths are checked only when a run ends, so wrap is harmless
   always_ff @(posedge clk)
   begin
      lastRxd <= hostRxd;
      hiCnt <= irPulseOut ? hiCnt + 16'h1 : 16'h0;
      runCnt <= (hostRxd == lastRxd) ? runCnt + 16'h1 : 16'h1;
      sinceWake <= (reset || lowPower) ? 16'h0 :
         sinceWake + {15'h0, ~&sinceWake};
   end
   property p_rst;
      $fell(reset) |-> hostRxd && !irPulseOut && lowPower && !linkReady;
   endproperty
   a_rst: assert property (p_rst) else $error("reset idle");
   property p_lp;
      lowPower && $past(lowPower) |-> hostRxd && !irPulseOut && !linkReady;
   endproperty
   a_lp: assert property (p_lp) else $error("low power idle");
   property p_en;
      $fell(enable) |-> ##[1:4] lowPower;
   endproperty
   a_en: assert property (p_en) else $error("enable low");
   property p_pulse;
      disable iff (reset || lowPower)
      $fell(irPulseOut) |-> hiCnt == 16'(3 * IR_TICK_CYC[irRateSel]);
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_bit;
      disable iff (reset || lowPower) $rose(hostRxd) |->
         runCnt % 16'(16 * HOST_TICK_CYC[{rateSelHi, rateSelLo}]) == 16'h0;
   endproperty
   a_bit: assert property (p_bit) else $error("bit");
   property p_wake_early;
      linkReady |-> sinceWake >= 16'(WAKE_CYC) - 16'h2;
   endproperty
   a_wake_early: assert property (p_wake_early) else $error("early");
   property p_wake_late;
      sinceWake == 16'(WAKE_CYC) + 16'h3 |-> linkReady;
   endproperty
   a_wake_late: assert property (p_wake_late) else $error("late");
   property p_duplex;
      !(irPulseOut && !hostRxd);
   endproperty
   a_duplex: assert property (p_duplex) else $error("duplex");
   c_tx: cover property ($fell(hostRxd));
   c_ir: cover property ($rose(irPulseOut));
   c_rdy: cover property ($rose(linkReady));
endmodule : ipc_codec_checker

bind ipc_codec ipc_codec_checker u_ipc_codec_checker (.clk, .reset, .enable,
   .rateSelHi, .rateSelLo, .irRateSel, .hostTxd, .irPulseIn, .hostRxd,
   .irPulseOut, .lowPower, .linkReady);

// >>> verif/ipc_far_end.sv
`timescale 1ns/1ps
module ipc_far_end import ipc_pkg::*; (
   // Clock
   input wire logic clk,
   // Host side
   output logic hostTxd = 1'b1,
   input wire logic hostRxd,
   // Transceiver side
   output logic irPulseIn = 1'b1,
   input wire logic irPulseOut
);
   int hostBit = 16 * HOST_TICK_CYC[3];
   int irTick = IR_TICK_CYC[4];
   task automatic hostSend(input logic [7:0] b);
      for (int i = 0; i < 10; i++)
      begin
         hostTxd = 1'({1'b1, b, 1'b0} >> i);
         repeat (hostBit) @(negedge clk);
      end
   endtask : hostSend
   task automatic irSend(input logic [7:0] b);
      for (int i = 0; i < 10; i++)
      begin
         irPulseIn = 1'({1'b1, b, 1'b0} >> i);
         repeat (3 * irTick) @(negedge clk);
         irPulseIn = 1'b1;
         repeat (13 * irTick) @(negedge clk);
      end
   endtask : irSend
   task automatic hostRecv(output logic [8:0] v);
      int n;
      n = 0;
      while (hostRxd !== 1'b0 && n < 30000)
      begin
         @(negedge clk);
         n++;
      end
      repeat (hostBit / 2) @(negedge clk);
      for (int i = 0; i < 9; i++)
      begin
         repeat (hostBit) @(negedge clk);
         v[i] = hostRxd;
      end
      if (n == 30000)
         v = 'x;
   endtask : hostRecv
   task automatic irRecv(output logic [8:0] v);
      int n;
      logic seen;
      n = 0;
      while (irPulseOut !== 1'b1 && n < 30000)
      begin
         @(negedge clk);
         n++;
      end
      // Start pulse sits at ticks 7..9; windows open at tick 3 of each bit
      repeat (12 * irTick) @(negedge clk);
      for (int i = 0; i < 9; i++)
      begin
         seen = 1'b0;
         repeat (16 * irTick)
         begin
            @(negedge clk);
            seen = seen | irPulseOut;
         end
         v[i] = ~seen;
      end
      if (n == 30000)
         v = 'x;
   endtask : irRecv
endmodule : ipc_far_end

// >>> verif/ipc_codec_tb.sv
`timescale 1ns/1ps
module ipc_codec_tb import ipc_pkg::*;;
   typedef struct packed {logic toHost; logic [7:0] data;} ipc_row_type;
   ipc_row_type rows [6] = '{'{1'b0, 8'h00}, '{1'b0, 8'hff}, '{1'b0, 8'ha5},
      '{1'b1, 8'h5a}, '{1'b1, 8'h00}, '{1'b1, 8'hff}};
   logic clk = 1'b0;
   logic reset, enable, rateSelHi, rateSelLo;
   logic [2:0] irRateSel;
   logic hostTxd, hostRxd, irPulseIn, irPulseOut, lowPower, linkReady;
   logic [8:0] v;
   int n_mismatch = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   ipc_codec u_ipc_codec (.clk, .reset, .enable, .rateSelHi, .rateSelLo,
      .irRateSel, .hostTxd, .hostRxd, .irPulseIn, .irPulseOut, .lowPower,
      .linkReady);
   ipc_far_end u_ipc_far_end (.clk, .hostTxd, .hostRxd, .irPulseIn,
      .irPulseOut);
   task automatic check(input string what, input logic [8:0] seen,
      input logic [8:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic waitReady(output int n);
      n = 0;
      while (linkReady !== 1'b1 && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
      check("ready", 9'(linkReady), 9'h001);
   endtask : waitReady
   task automatic xfer(input logic toHost, input logic [7:0] d);
      logic [8:0] r;
      int n;
      fork
         if (toHost)
            u_ipc_far_end.irSend(d);
         else
            u_ipc_far_end.hostSend(d);
         if (toHost)
            u_ipc_far_end.hostRecv(r);
         else
            u_ipc_far_end.irRecv(r);
      join
      check("byte", r, {1'b1, d});
      waitReady(n);
   endtask : xfer
   initial
   begin
      int n;
      reset = 1'b1;
      enable = 1'b1;
      rateSelHi = 1'b1;
      rateSelLo = 1'b1;
      irRateSel = 3'h4;
      repeat (20) @(negedge clk);
      check("reset", 9'({hostRxd, irPulseOut, lowPower, linkReady}), 9'h00a);
      reset = 1'b0;
      waitReady(n);
      foreach (rows[i])
         xfer(rows[i].toHost, rows[i].data);
      // Back to back at a slower infrared rate: second byte waits in buffer
      irRateSel = 3'h3;
      u_ipc_far_end.irTick = IR_TICK_CYC[3];
      fork
         begin
            u_ipc_far_end.hostSend(8'h81);
            u_ipc_far_end.hostSend(8'h7e);
         end
         begin
            u_ipc_far_end.irRecv(v);
            check("first", v, 9'h181);
            u_ipc_far_end.irRecv(v);
            check("second", v, 9'h17e);
         end
      join
      irRateSel = 3'h4;
      u_ipc_far_end.irTick = IR_TICK_CYC[4];
      waitReady(n);
      enable = 1'b0;
      repeat (5) @(negedge clk);
      check("lowpwr", 9'({lowPower, linkReady}), 9'h002);
      enable = 1'b1;
      waitReady(n);
      check("wake", 9'(n >= WAKE_CYC), 9'h001);
      for (int r = 0; r < 4; r++)
      begin
         {rateSelHi, rateSelLo} = 2'(r);
         u_ipc_far_end.hostBit = 16 * HOST_TICK_CYC[r];
         repeat (4) @(negedge clk);
         xfer(1'b1, 8'h4b + 8'(r));
      end
      summarize();
   end
   initial
   begin
      repeat (100000) @(negedge clk);
      n_mismatch++;
      summarize();
   end
endmodule : ipc_codec_tb
